// ==== rtl/scl_pkg.sv ====
// package for the short-circuit latch-off block
package scl_pkg;

   // ----------------------------------------------------------------
   // option word layout
   // ----------------------------------------------------------------
   localparam int unsigned OPT_WORD_W  = 16;
   localparam int unsigned HS_SEL_LSB  = 7;
   localparam int unsigned HS_SEL_MSB  = 8;

   // ----------------------------------------------------------------
   // thresholds in millivolts
   // ----------------------------------------------------------------
   localparam int unsigned THR_W       = 10;
   localparam logic [9:0]  LS_THR_MV   = 10'h06E; // 110 mV
   localparam logic [9:0]  HS_THR_00   = 10'h12C; // 300 mV
   localparam logic [9:0]  HS_THR_01   = 10'h1F4; // 500 mV
   localparam logic [9:0]  HS_THR_10   = 10'h2BC; // 700 mV
   localparam logic [9:0]  HS_THR_11   = 10'h384; // 900 mV

   // ----------------------------------------------------------------
   // event counting and timing
   // ----------------------------------------------------------------
   localparam int unsigned EVT_LIMIT   = 7;
   localparam int unsigned CNT_W       = 3;
   localparam int unsigned CLK_MHZ     = 100;
   localparam int unsigned BLANK_NS    = 150;
   localparam int unsigned BLANK_CYC   = (BLANK_NS * CLK_MHZ + 999) / 1000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCL_IDLE  = 2'b00,
      SCL_BLANK = 2'b01,
      SCL_SAMP  = 2'b10,
      SCL_DONE  = 2'b11
   } scl_phase_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
   } scl_gate_t;

   typedef struct packed {
      logic [CNT_W-1:0] hs_cnt;
      logic [CNT_W-1:0] ls_cnt;
      logic             latched;
   } scl_status_t;

   // high-side threshold decode for the core's comparator model
   function automatic logic [9:0] scl_hs_thr(input logic [1:0] sel);
      unique case (sel)
         2'b00: scl_hs_thr = HS_THR_00;
         2'b01: scl_hs_thr = HS_THR_01;
         2'b10: scl_hs_thr = HS_THR_10;
         2'b11: scl_hs_thr = HS_THR_11;
      endcase
   endfunction : scl_hs_thr

endpackage : scl_pkg

// ==== rtl/scl_sync.sv ====
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module scl_sync
   import scl_pkg::*;
#(
   parameter int unsigned WIDTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   initial begin
      if (WIDTH < 1) $error("scl_sync width must be at least one");
   end

   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

   // ----------------------------------------------------------------
   // chain; first stage feeds only the second
   // ----------------------------------------------------------------
   always_comb begin
      s1_d  = async_in;
      s2_d  = s1_q;
      s3_d  = s2_q;
      out_d = out_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;

endmodule : scl_sync
`default_nettype wire

// ==== rtl/scl_core.sv ====
// short-circuit latch-off core: blanking, event counters, latch
// Notes on behaviour
// - sample comparators once per cycle after blanking
// - separate high/low comparators, each own counter
// - seventh event latches off, switching stops
// - only adapter reconnect clears latched off
// - low side: switch node vs ground, 110mV
// - negative freewheel drop never counts
// - high side: input sense vs switch node
// - option bits 8:7 pick 300-900mV threshold
`timescale 1ns/100ps
`default_nettype none
module scl_core
   import scl_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = BLANK_CYC,
   parameter int unsigned EVENT_LIMIT  = EVT_LIMIT
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  pwm_hs_req,
   input  wire logic                  pwm_ls_req,
   input  wire logic signed [10:0]    ls_drop_mv,
   input  wire logic signed [10:0]    hs_drop_mv,
   input  wire logic [OPT_WORD_W-1:0] charger_option_word,
   output var  scl_gate_t             gate_drive,
   output var  logic                  fault,
   output var  scl_status_t           status
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the blank counter is eight bits wide, the event counters three
   initial begin
      if (BLANK_CYCLES < 1 || BLANK_CYCLES > 255)
         $error("blanking count must be 1..255");
      if (EVENT_LIMIT < 1 || EVENT_LIMIT > 7)
         $error("event limit must fit the 3-bit counters");
   end

   // ----------------------------------------------------------------
   // pwm requests arrive from the modulator pins; synchronise them
   // ----------------------------------------------------------------
   // three flops cost five cycles of gate latency but reject pin glitches
   logic [1:0] pwm_sync;

   scl_sync #(
      .WIDTH    (2)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({pwm_hs_req, pwm_ls_req}),
      .sync_out (pwm_sync)
   );

   // ----------------------------------------------------------------
   // comparator model: sampled drop against thresholds
   // ----------------------------------------------------------------
   // drops arrive as signed millivolts; this stands in for analog comparators
   logic [9:0]  hs_thr;
   logic        ls_over;
   logic        hs_over;

   // threshold only read when sampling, so a host change mid-cycle is harmless
   always_comb begin
      hs_thr  = scl_hs_thr(charger_option_word[HS_SEL_MSB:HS_SEL_LSB]);
      // signed compare: freewheeling gives a negative drop, never over
      ls_over = (ls_drop_mv > $signed({1'b0, LS_THR_MV}));
      hs_over = (hs_drop_mv > $signed({1'b0, hs_thr}));
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   scl_phase_t       hs_ph_q,  hs_ph_d;
   scl_phase_t       ls_ph_q,  ls_ph_d;
   logic [7:0]       hs_bl_q,  hs_bl_d;
   logic [7:0]       ls_bl_q,  ls_bl_d;
   logic [CNT_W-1:0] hs_cnt_q, hs_cnt_d;
   logic [CNT_W-1:0] ls_cnt_q, ls_cnt_d;
   logic             latch_q,  latch_d;
   logic             hs_en_q,  hs_en_d;
   logic             ls_en_q,  ls_en_d;
   logic             hs_evt,   ls_evt;
   // last cycle's enables: a fresh turn-on re-arms the sample
   logic             prev_hs_q, prev_ls_q;

   // total count; seventh event of either kind trips the latch
   function automatic logic [CNT_W:0] total(input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b);
      total = {1'b0, a} + {1'b0, b};
   endfunction : total

   // ----------------------------------------------------------------
   // per-switch phase: idle, blank after turn-on, sample once, done
   // ----------------------------------------------------------------
   always_comb begin
      hs_ph_d = hs_ph_q;
      ls_ph_d = ls_ph_q;
      hs_bl_d = hs_bl_q;
      ls_bl_d = ls_bl_q;
      hs_evt  = 1'b0;
      ls_evt  = 1'b0;
      // a switch held on is sampled once only; a new turn-on re-arms it
      // high side
      if (!hs_en_q) begin
         hs_ph_d = SCL_IDLE;
      end else begin
         unique case (hs_ph_q)
            SCL_IDLE: begin
               if (!prev_hs_q) begin // new transition: start blanking
                  hs_ph_d = SCL_BLANK;
                  hs_bl_d = 8'(BLANK_CYCLES - 1);
               end
            end
            SCL_BLANK: begin
               if (hs_bl_q == 8'h00) hs_ph_d = SCL_SAMP;
               else hs_bl_d = hs_bl_q - 8'h01;
            end
            SCL_SAMP: begin
               hs_evt  = hs_over;
               hs_ph_d = SCL_DONE;
            end
            SCL_DONE: hs_ph_d = SCL_DONE;
         endcase
      end
      // low side
      if (!ls_en_q) begin
         ls_ph_d = SCL_IDLE;
      end else begin
         unique case (ls_ph_q)
            SCL_IDLE: begin
               if (!prev_ls_q) begin
                  ls_ph_d = SCL_BLANK;
                  ls_bl_d = 8'(BLANK_CYCLES - 1);
               end
            end
            SCL_BLANK: begin
               if (ls_bl_q == 8'h00) ls_ph_d = SCL_SAMP;
               else ls_bl_d = ls_bl_q - 8'h01;
            end
            SCL_SAMP: begin
               ls_evt  = ls_over;
               ls_ph_d = SCL_DONE;
            end
            SCL_DONE: ls_ph_d = SCL_DONE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // counters, latch and gate enables
   // ----------------------------------------------------------------
   // next counts, latch and enables; gates drop on the tripping edge itself
   always_comb begin
      hs_cnt_d = hs_cnt_q;
      ls_cnt_d = ls_cnt_q;
      latch_d  = latch_q;
      if (!latch_q) begin
         if (hs_evt) hs_cnt_d = hs_cnt_q + 3'h1;
         if (ls_evt) ls_cnt_d = ls_cnt_q + 3'h1;
         if (total(hs_cnt_d, ls_cnt_d) >= 4'(EVENT_LIMIT)) latch_d = 1'b1;
      end
      // nothing but rst_n (adapter present) releases the latch, so a
      // hard short cannot restart into the same fault over and over
      hs_en_d = pwm_sync[1] & ~latch_d;
      ls_en_d = pwm_sync[0] & ~pwm_sync[1] & ~latch_d;
   end

   // phase, blank and edge-detect flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_ph_q   <= SCL_IDLE;
         ls_ph_q   <= SCL_IDLE;
         hs_bl_q   <= 8'h00;
         ls_bl_q   <= 8'h00;
         prev_hs_q <= 1'b0;
         prev_ls_q <= 1'b0;
      end else begin
         hs_ph_q   <= hs_ph_d;
         ls_ph_q   <= ls_ph_d;
         hs_bl_q   <= hs_bl_d;
         ls_bl_q   <= ls_bl_d;
         prev_hs_q <= hs_en_q;
         prev_ls_q <= ls_en_q;
      end
   end

   // counter, latch and gate flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_cnt_q  <= 3'h0;
         ls_cnt_q  <= 3'h0;
         latch_q   <= 1'b0;
         hs_en_q   <= 1'b0;
         ls_en_q   <= 1'b0;
      end else begin
         hs_cnt_q  <= hs_cnt_d;
         ls_cnt_q  <= ls_cnt_d;
         latch_q   <= latch_d;
         hs_en_q   <= hs_en_d;
         ls_en_q   <= ls_en_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from flops
   // ----------------------------------------------------------------
   assign gate_drive = '{
      hs_on: hs_en_q,
      ls_on: ls_en_q
   };
   assign fault      = latch_q;
   assign status     = '{
      hs_cnt:  hs_cnt_q,
      ls_cnt:  ls_cnt_q,
      latched: latch_q
   };

endmodule : scl_core
`default_nettype wire

// ==== verification/scl_core_assertions.sv ====
// concurrent checks on the ports of the latch-off core
`timescale 1ns/100ps
`default_nettype none
module scl_core_chk
   import scl_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = BLANK_CYC,
   parameter int unsigned EVENT_LIMIT  = EVT_LIMIT
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic signed [10:0]    ls_drop_mv,
   input  wire logic signed [10:0]    hs_drop_mv,
   input  wire logic [OPT_WORD_W-1:0] charger_option_word,
   input  wire scl_gate_t             gate_drive,
   input  wire logic                  fault,
   input  wire scl_status_t           status
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   int thr;
   int cnt_sum;
   int hs_run;
   int ls_run;
   // own decode of the option code, kept apart from the design's function
   always_comb begin
      case (charger_option_word[8:7])
         2'h0: thr = int'(HS_THR_00);
         2'h1: thr = int'(HS_THR_01);
         2'h2: thr = int'(HS_THR_10);
         default: thr = int'(HS_THR_11);
      endcase
   end
   // both counters feed one limit
   always_comb cnt_sum = int'(status.hs_cnt) + int'(status.ls_cnt);
   // cycles each gate has stood on, to prove the blank really elapsed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_run <= 0;
         ls_run <= 0;
      end else begin
         hs_run <= gate_drive.hs_on ? hs_run + 1 : 0;
         ls_run <= gate_drive.ls_on ? ls_run + 1 : 0;
      end
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_latch_at_limit: assert property (fault == (cnt_sum == EVENT_LIMIT))
      else $error("latch does not match event total");
   a_fault_holds: assert property (fault |=> fault)
      else $error("fault cleared without reset");
   a_latch_gates_off: assert property (fault |-> gate_drive == '0)
      else $error("gate driven while latched");
   a_count_frozen: assert property (fault |=> $stable(status))
      else $error("counters moved while latched");
   a_hs_step: assert property ($changed(status.hs_cnt) |->
      status.hs_cnt == $past(status.hs_cnt) + 3'h1)
      else $error("high-side count did not step by one");
   a_hs_blank: assert property ($changed(status.hs_cnt) |-> hs_run > int'(BLANK_CYCLES))
      else $error("high-side sample inside blanking");
   a_ls_blank: assert property ($changed(status.ls_cnt) |-> ls_run > int'(BLANK_CYCLES))
      else $error("low-side sample inside blanking");
   a_hs_once: assert property ($changed(status.hs_cnt) |=> $stable(status.hs_cnt) [*4])
      else $error("second high-side sample in one period");
   a_hs_thresh: assert property ($changed(status.hs_cnt) |->
      int'($past(hs_drop_mv)) > $past(thr))
      else $error("high-side event below threshold");
   a_ls_thresh: assert property ($changed(status.ls_cnt) |->
      int'($past(ls_drop_mv)) > int'(LS_THR_MV))
      else $error("low-side event below threshold");
   c_latch: cover property ($rose(fault));
   c_hs_event: cover property ($changed(status.hs_cnt));
   c_ls_event: cover property ($changed(status.ls_cnt));
endmodule : scl_core_chk
bind scl_core scl_core_chk #(.BLANK_CYCLES(BLANK_CYCLES), .EVENT_LIMIT(EVENT_LIMIT))
   u_chk (.clk(clk), .rst_n(rst_n),
   .ls_drop_mv(ls_drop_mv), .hs_drop_mv(hs_drop_mv),
   .charger_option_word(charger_option_word), .gate_drive(gate_drive), .fault(fault),
   .status(status));
`default_nettype wire

// ==== verification/scl_power_stage.sv ====
// behavioural power stage: switches and input sense
`timescale 1ns/100ps
`default_nettype none
module scl_power_stage
   import scl_pkg::*;
(
   input  wire logic               clk,
   input  wire scl_gate_t          gate_drive,
   input  wire logic signed [10:0] hs_on_mv,
   input  wire logic signed [10:0] ls_on_mv,
   output var  logic signed [10:0] hs_drop_mv,
   output var  logic signed [10:0] ls_drop_mv
);
   logic tgl = 1'b0;
   initial begin
      hs_drop_mv = 11'sh000;
      ls_drop_mv = 11'sh000;
   end
   // an off switch rings, so a late sample never sees a held value
   always @(negedge clk) begin
      tgl <= ~tgl;
      hs_drop_mv <= gate_drive.hs_on ? hs_on_mv : (tgl ? 11'sh3E8 : -11'sh3E8);
      ls_drop_mv <= gate_drive.ls_on ? ls_on_mv : (tgl ? -11'sh3E8 : 11'sh3E8);
   end
endmodule : scl_power_stage
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the latch-off core
`timescale 1ns/100ps
`default_nettype none
module tb
   import scl_pkg::*;
;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               hs_req = 1'b0;
   logic               ls_req = 1'b0;
   logic signed [10:0] hs_mv = 11'sh000;
   logic signed [10:0] ls_mv = 11'sh000;
   logic signed [10:0] hs_drop;
   logic signed [10:0] ls_drop;
   logic [15:0]        opt = 16'h0000;
   logic               lat = 1'b0;
   logic               dual = 1'b0;
   scl_gate_t          gate;
   logic               fault;
   scl_status_t        status;
   scl_status_t        prev;
   scl_status_t        exp_q[$];
   int n_mismatch = 0, compares = 0, seed = 51794, h_c = 0, l_c = 0;
   int thr_t[4] = '{int'(HS_THR_00), int'(HS_THR_01), int'(HS_THR_10), int'(HS_THR_11)};
   int ls_t = int'(LS_THR_MV);
   always #5 clk = ~clk;
   scl_core DUT (.clk(clk), .rst_n(rst_n), .pwm_hs_req(hs_req), .pwm_ls_req(ls_req),
      .ls_drop_mv(ls_drop), .hs_drop_mv(hs_drop), .charger_option_word(opt),
      .gate_drive(gate), .fault(fault), .status(status));
   scl_power_stage u_stage (.clk(clk), .gate_drive(gate), .hs_on_mv(hs_mv),
      .ls_on_mv(ls_mv), .hs_drop_mv(hs_drop), .ls_drop_mv(ls_drop));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out();
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // one on-period; the expected counter state is noted when it must count
   // held past sync, blank and the single sample before the gates are checked
   task automatic pulse(input logic hs, input int mv, input logic cnt);
      @(negedge clk);
      if (hs) hs_mv = 11'(mv);
      else ls_mv = 11'(mv);
      hs_req = hs;
      ls_req = ~hs | dual;
      if (cnt && !lat) begin
         if (hs) h_c++;
         else l_c++;
         lat = (h_c + l_c == EVT_LIMIT);
         exp_q.push_back({3'(h_c), 3'(l_c), lat});
      end
      repeat (BLANK_CYC + 9) @(negedge clk);
      chk("gates", {5'h00, lat, ~lat & hs, ~lat & ~hs}, {5'h00, fault, gate});
      hs_req = 1'b0;
      ls_req = 1'b0;
      repeat (8) @(negedge clk);
   endtask : pulse
   // ----------------------------------------------------------------
   // watcher and main sequence
   // ----------------------------------------------------------------
   // takes the oldest note whenever the counters move
   always @(negedge clk) begin
      if (!rst_n) prev = '0;
      else if (status !== prev) begin
         prev = status;
         chk("status", exp_q.size() ? {1'b0, exp_q.pop_front()} : 8'hFF, {1'b0, status});
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      for (int c = 0; c < 4; c++) begin
         opt = (16'($random(seed)) & 16'hFE7F) | 16'(c << 7);
         pulse(1'b1, thr_t[c], 1'b0);
         pulse(1'b1, thr_t[c] + 1, 1'b1);
      end
      pulse(1'b0, -2 * ls_t, 1'b0);
      pulse(1'b0, ls_t, 1'b0);
      pulse(1'b0, ls_t + 1, 1'b1);
      // both requests high: the low side must stay off and uncounted
      dual = 1'b1;
      repeat (4) begin
         opt[8:7] = 2'($random(seed));
         pulse(1'b1, $random(seed) % thr_t[opt[8:7]], 1'b0);
      end
      dual = 1'b0;
      pulse(1'b0, 4 * ls_t, 1'b1);
      pulse(1'b1, thr_t[3] + 50, 1'b1);
      // a latched part must ignore requests and option changes
      opt = 16'h0000;
      pulse(1'b1, thr_t[3] + 50, 1'b1);
      pulse(1'b0, 4 * ls_t, 1'b1);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      chk("reset", 8'h00, {fault, status});
      rst_n = 1'b1;
      h_c = 0;
      l_c = 0;
      lat = 1'b0;
      pulse(1'b1, thr_t[0] + 1, 1'b1);
      for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(negedge clk);
      chk("pending", 8'h00, 8'(exp_q.size()));
      close_out();
   end
endmodule : tb
`default_nettype wire
